// ### hdl/mfpc_pkg.sv
package mfpc_pkg;
	localparam int          MFPC_PINS         = 4;
	localparam int          MFPC_CLKOUTS      = 8;
	localparam int          MFPC_ADDR_W       = 16;
	localparam int          MFPC_DATA_W       = 8;
	localparam int          MFPC_CODE_W       = 3;

	// Register byte addresses on the host port
	localparam logic [15:0] MFPC_ADDR_DIR     = 16'h006E;
	localparam logic [15:0] MFPC_ADDR_IFN2    = 16'h006F;
	localparam logic [15:0] MFPC_ADDR_IFN1    = 16'h0070;
	localparam logic [15:0] MFPC_ADDR_IFN0    = 16'h0071;
	localparam logic [15:0] MFPC_ADDR_OFN2    = 16'h0072;
	localparam logic [15:0] MFPC_ADDR_OFN1    = 16'h0073;
	localparam logic [15:0] MFPC_ADDR_OFN0    = 16'h0074;
	localparam logic [15:0] MFPC_ADDR_RSVD    = 16'h0075;
	localparam logic [15:0] MFPC_ADDR_OVAL    = 16'h0076;
	localparam logic [15:0] MFPC_ADDR_IVAL    = 16'h0219;

	// Writable bits of each register; all others read as zero
	localparam logic [3:0]  MFPC_MASK_FULL    = 4'h7 | 4'h8;
	localparam logic [3:0]  MFPC_MASK_LOW3    = 4'h7;

	localparam logic [3:0]  MFPC_RST_NIBBLE   = 4'h0;
	localparam logic [7:0]  MFPC_RST_BYTE     = 8'h00;
	localparam logic [3:0]  MFPC_ZERO_NIBBLE  = 4'h0;

	// Function codes
	localparam logic [2:0]  MFPC_FN_GP        = 3'h0;
	localparam logic [2:0]  MFPC_FN_SEL_A     = 3'h1;
	localparam logic [2:0]  MFPC_FN_SEL_B     = 3'h2;
	localparam logic [2:0]  MFPC_FN_REFSEL    = 3'h5;

	// Pin that may carry the manual reference select
	localparam int          MFPC_REFSEL_PIN   = 2;
endpackage : mfpc_pkg

// ### hdl/mfpc_pin_sync.sv
`timescale 1ns/100ps
module mfpc_pin_sync (
	input  wire logic                          i_clk,
	input  wire logic                          i_sys_rst,
	input  wire logic [mfpc_pkg::MFPC_PINS-1:0] i_async,
	output logic      [mfpc_pkg::MFPC_PINS-1:0] o_sync
);
	import mfpc_pkg::*;

	logic [MFPC_PINS-1:0] meta;

	// Two-stage synchroniser; the first stage feeds only the second
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			meta   <= MFPC_RST_NIBBLE;
			o_sync <= MFPC_RST_NIBBLE;
		end else begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end
endmodule : mfpc_pin_sync

// ### hdl/mfpc_pin_control.sv
`timescale 1ns/100ps
module mfpc_pin_control (
	input  wire logic                                i_clk,
	input  wire logic                                i_sys_rst,
	// Register port from the serial host interface
	input  wire logic [mfpc_pkg::MFPC_ADDR_W-1:0]    i_reg_addr,
	input  wire logic                                i_reg_wr,
	input  wire logic [mfpc_pkg::MFPC_DATA_W-1:0]    i_reg_wdata,
	input  wire logic                                i_reg_rd,
	output logic      [mfpc_pkg::MFPC_DATA_W-1:0]    o_reg_rdata,
	// Multifunction pins
	input  wire logic [mfpc_pkg::MFPC_PINS-1:0]      i_pin,
	output logic      [mfpc_pkg::MFPC_PINS-1:0]      o_pin,
	output logic      [mfpc_pkg::MFPC_PINS-1:0]      o_pin_oe_n,
	// Status flags from the PLL core
	input  wire logic                                i_loss_of_lock,
	input  wire logic                                i_holdover,
	input  wire logic                                i_ref0_los,
	input  wire logic                                i_ref1_los,
	// Controls to the clock output and reference logic
	output logic      [mfpc_pkg::MFPC_CLKOUTS-1:0]   o_clkout_pin_enable,
	output logic      [mfpc_pkg::MFPC_CLKOUTS-1:0]   o_clkout_pin_gated,
	output logic                                     o_manual_reference_select,
	output logic                                     o_manual_reference_select_valid
);
	import mfpc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	logic [3:0] pin_direction;
	logic [3:0] input_function_bit2;
	logic [3:0] input_function_bit1;
	logic [3:0] input_function_bit0;
	logic [3:0] output_function_bit2;
	logic [3:0] output_function_bit1;
	logic [3:0] output_function_bit0;
	logic [3:0] pin_output_values;
	logic [3:0] pin_sync;

	wire        wr_dir  = i_reg_wr && (i_reg_addr == MFPC_ADDR_DIR);
	wire        wr_ifn2 = i_reg_wr && (i_reg_addr == MFPC_ADDR_IFN2);
	wire        wr_ifn1 = i_reg_wr && (i_reg_addr == MFPC_ADDR_IFN1);
	wire        wr_ifn0 = i_reg_wr && (i_reg_addr == MFPC_ADDR_IFN0);
	wire        wr_ofn2 = i_reg_wr && (i_reg_addr == MFPC_ADDR_OFN2);
	wire        wr_ofn1 = i_reg_wr && (i_reg_addr == MFPC_ADDR_OFN1);
	wire        wr_ofn0 = i_reg_wr && (i_reg_addr == MFPC_ADDR_OFN0);
	wire        wr_oval = i_reg_wr && (i_reg_addr == MFPC_ADDR_OVAL);
	wire [3:0]  wnib    = i_reg_wdata[3:0];

	////////////////////////////////////////////////////////////////////////////////
	// Register storage

	// Pin 3 has no storage for input bit 2 or output bit 0
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pin_direction <= MFPC_RST_NIBBLE;
		end else if (wr_dir) begin
			pin_direction <= wnib & MFPC_MASK_FULL;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			input_function_bit2 <= MFPC_RST_NIBBLE;
		end else if (wr_ifn2) begin
			input_function_bit2 <= wnib & MFPC_MASK_LOW3;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			input_function_bit1 <= MFPC_RST_NIBBLE;
		end else if (wr_ifn1) begin
			input_function_bit1 <= wnib & MFPC_MASK_FULL;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			input_function_bit0 <= MFPC_RST_NIBBLE;
		end else if (wr_ifn0) begin
			input_function_bit0 <= wnib & MFPC_MASK_FULL;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			output_function_bit2 <= MFPC_RST_NIBBLE;
		end else if (wr_ofn2) begin
			output_function_bit2 <= wnib & MFPC_MASK_FULL;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			output_function_bit1 <= MFPC_RST_NIBBLE;
		end else if (wr_ofn1) begin
			output_function_bit1 <= wnib & MFPC_MASK_FULL;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			output_function_bit0 <= MFPC_RST_NIBBLE;
		end else if (wr_ofn0) begin
			output_function_bit0 <= wnib & MFPC_MASK_LOW3;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pin_output_values <= MFPC_RST_NIBBLE;
		end else if (wr_oval) begin
			pin_output_values <= wnib & MFPC_MASK_FULL;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin input synchroniser

	mfpc_pin_sync u_sync (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_async   (i_pin),
		.o_sync    (pin_sync)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Function decoding

	// Reduce an input code to one that is valid for the pin; reserved codes fall back to plain
	function automatic logic [2:0] mfpc_in_code(input int pin, input logic [2:0] code);
		logic [2:0] res;
		res = MFPC_FN_GP;
		if (code == MFPC_FN_SEL_A || code == MFPC_FN_SEL_B)
			res = code;
		else if (pin == MFPC_REFSEL_PIN && code == MFPC_FN_REFSEL)
			res = code;
		return res;
	endfunction : mfpc_in_code

	// Reduce an output code to one that is valid for the pin; reserved codes fall back to plain
	function automatic logic [2:0] mfpc_out_code(input int pin, input logic [2:0] code);
		logic [2:0] res;
		res = MFPC_FN_GP;
		case (pin)
			0: if (code == MFPC_FN_SEL_A) res = code;
			1: if (code == MFPC_FN_SEL_A) res = code;
			2: if (code == MFPC_FN_SEL_A || code == MFPC_FN_SEL_B) res = code;
			3: if (code == MFPC_FN_SEL_B) res = code;
			default: res = MFPC_FN_GP;
		endcase
		return res;
	endfunction : mfpc_out_code

	// Select what a pin drives in output mode
	function automatic logic mfpc_out_level(input int pin, input logic [2:0] code, input logic stored,
		input logic lol, input logic hold, input logic los0, input logic los1);
		logic res;
		res = stored;
		case (pin)
			0: if (code == MFPC_FN_SEL_A) res = lol;
			1: if (code == MFPC_FN_SEL_A) res = hold;
			2: begin
				if (code == MFPC_FN_SEL_A) res = los0;
				else if (code == MFPC_FN_SEL_B) res = los1;
			end
			3: if (code == MFPC_FN_SEL_B) res = los1;
			default: res = stored;
		endcase
		return res;
	endfunction : mfpc_out_level

	logic [3:0] gp_input;
	logic [3:0] next_pin;
	logic [3:0] oe_a;
	logic [3:0] oe_b;
	logic [3:0] refsel_sel;

	////////////////////////////////////////////////////////////////////////////////
	// Per-pin selection

	genvar g;
	generate
		for (g = 0; g < MFPC_PINS; g++) begin : g_pin
			wire [2:0] in_raw  = {input_function_bit2[g], input_function_bit1[g], input_function_bit0[g]};
			wire [2:0] out_raw = {output_function_bit2[g], output_function_bit1[g], output_function_bit0[g]};
			wire [2:0] in_eff  = mfpc_in_code(g, in_raw);
			wire [2:0] out_eff = mfpc_out_code(g, out_raw);
			wire       is_in   = !pin_direction[g];
			assign gp_input[g]   = is_in && (in_eff == MFPC_FN_GP);
			assign oe_a[g]       = is_in && (in_eff == MFPC_FN_SEL_A);
			assign oe_b[g]       = is_in && (in_eff == MFPC_FN_SEL_B);
			assign refsel_sel[g] = is_in && (in_eff == MFPC_FN_REFSEL);
			assign next_pin[g]   = mfpc_out_level(g, out_eff, pin_output_values[g],
				i_loss_of_lock, i_holdover, i_ref0_los, i_ref1_los);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Pin drive and controls

	wire [7:0] next_gated  = {oe_b, oe_a};
	wire [7:0] next_enable = ~next_gated | {pin_sync, pin_sync};

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_pin <= MFPC_RST_NIBBLE;
		end else begin
			o_pin <= next_pin & pin_direction;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_pin_oe_n <= ~MFPC_RST_NIBBLE;
		end else begin
			o_pin_oe_n <= ~pin_direction;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_clkout_pin_gated <= MFPC_RST_BYTE;
		end else begin
			o_clkout_pin_gated <= next_gated;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_clkout_pin_enable <= ~MFPC_RST_BYTE;
		end else begin
			o_clkout_pin_enable <= next_enable;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_manual_reference_select <= MFPC_RST_BYTE[0];
		end else begin
			o_manual_reference_select <= refsel_sel[MFPC_REFSEL_PIN] && pin_sync[MFPC_REFSEL_PIN];
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_manual_reference_select_valid <= MFPC_RST_BYTE[0];
		end else begin
			o_manual_reference_select_valid <= refsel_sel[MFPC_REFSEL_PIN];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data; reserved and unmapped locations read zero

	wire        rd_dir  = (i_reg_addr == MFPC_ADDR_DIR);
	wire        rd_ifn2 = (i_reg_addr == MFPC_ADDR_IFN2);
	wire        rd_ifn1 = (i_reg_addr == MFPC_ADDR_IFN1);
	wire        rd_ifn0 = (i_reg_addr == MFPC_ADDR_IFN0);
	wire        rd_ofn2 = (i_reg_addr == MFPC_ADDR_OFN2);
	wire        rd_ofn1 = (i_reg_addr == MFPC_ADDR_OFN1);
	wire        rd_ofn0 = (i_reg_addr == MFPC_ADDR_OFN0);
	wire        rd_oval = (i_reg_addr == MFPC_ADDR_OVAL);
	wire        rd_ival = (i_reg_addr == MFPC_ADDR_IVAL);
	wire [3:0]  rd_nib  = ({4{rd_dir}} & pin_direction)
		| ({4{rd_ifn2}} & input_function_bit2)
		| ({4{rd_ifn1}} & input_function_bit1)
		| ({4{rd_ifn0}} & input_function_bit0)
		| ({4{rd_ofn2}} & output_function_bit2)
		| ({4{rd_ofn1}} & output_function_bit1)
		| ({4{rd_ofn0}} & output_function_bit0)
		| ({4{rd_oval}} & pin_output_values)
		| ({4{rd_ival}} & pin_sync & gp_input);

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_reg_rdata <= MFPC_RST_BYTE;
		end else if (i_reg_rd) begin
			o_reg_rdata <= {MFPC_ZERO_NIBBLE, rd_nib};
		end
	end
endmodule : mfpc_pin_control

// ### tb/mfpc_pin_control_props.sv
`timescale 1ns/100ps
module mfpc_pin_control_props (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic [15:0] i_reg_addr,
	input  wire logic        i_reg_wr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_rd,
	input  wire logic [7:0]  o_reg_rdata,
	input  wire logic [3:0]  o_pin,
	input  wire logic [3:0]  o_pin_oe_n,
	input  wire logic [7:0]  o_clkout_pin_enable,
	input  wire logic [7:0]  o_clkout_pin_gated,
	input  wire logic        o_manual_reference_select,
	input  wire logic        o_manual_reference_select_valid
);
	import mfpc_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	wire [3:0] ctl = o_clkout_pin_gated[3:0] | o_clkout_pin_gated[7:4];
	a_dir_follows: assert property (i_reg_wr && i_reg_addr == MFPC_ADDR_DIR |->
		##2 o_pin_oe_n == ~$past(i_reg_wdata[3:0], 2)) else $error("direction not applied");
	a_reset_state: assert property ($fell(i_sys_rst) |-> o_pin_oe_n == 4'hF &&
		o_clkout_pin_enable == 8'hFF && o_clkout_pin_gated == 8'h00) else $error("bad state after reset");
	a_input_quiet: assert property ((o_pin & o_pin_oe_n) == 4'h0) else $error("input pin driven");
	a_ungated_high: assert property ((o_clkout_pin_enable | o_clkout_pin_gated) == 8'hFF)
		else $error("ungated enable low");
	a_gate_input: assert property ((ctl & ~o_pin_oe_n) == 4'h0) else $error("output pin gates");
	a_gate_single: assert property ((o_clkout_pin_gated[3:0] & o_clkout_pin_gated[7:4]) == 4'h0)
		else $error("pin gates two outputs");
	a_refsel_input: assert property (o_manual_reference_select_valid |-> o_pin_oe_n[2] && !ctl[2])
		else $error("select without input pin");
	a_refsel_idle: assert property (!o_manual_reference_select_valid |-> !o_manual_reference_select)
		else $error("select without valid");
	a_rsvd_zero: assert property (i_reg_rd && i_reg_addr == MFPC_ADDR_RSVD |=> o_reg_rdata == 8'h00)
		else $error("reserved read not zero");
	c_refsel: cover property (o_manual_reference_select_valid && o_manual_reference_select);
	c_gated: cover property (o_clkout_pin_gated[7:4] != 4'h0 && o_clkout_pin_enable != 8'hFF);
	c_out: cover property (o_pin != 4'h0);
endmodule : mfpc_pin_control_props
bind mfpc_pin_control mfpc_pin_control_props i_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
	.i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata), .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n), .o_clkout_pin_enable(o_clkout_pin_enable),
	.o_clkout_pin_gated(o_clkout_pin_gated), .o_manual_reference_select(o_manual_reference_select),
	.o_manual_reference_select_valid(o_manual_reference_select_valid));

// ### tb/mfpc_board.sv
`timescale 1ns/100ps
module mfpc_board (
	input  wire logic [3:0] i_drive,
	input  wire logic [3:0] i_pin_val,
	input  wire logic [3:0] i_oe_n,
	output logic      [3:0] o_wire
);
	// Board drives only where the device has released the pin
	assign o_wire = (i_oe_n & i_drive) | (~i_oe_n & i_pin_val);
endmodule : mfpc_board

// ### tb/multifunction_pin_control_test.sv
`timescale 1ns/100ps
module multifunction_pin_control_test;
	import mfpc_pkg::*;
	logic        i_clk = 0, rst = 1, wr = 0, rd = 0, lol = 0, hold = 0, l0 = 0, l1 = 0, rs, rsv, e_rs, e_rv;
	logic [15:0] addr = 0;
	logic [7:0]  wd = 0, rdat, en, gt, e_en, e_gt;
	logic [3:0]  brd = 0, dir, ov, op, oen, e_op, e_iv;
	logic [2:0]  ic[4], oc[4];
	logic [31:0] seed = 32'hd66c;
	logic [15:0] regs[9] = '{16'h006E, 16'h006F, 16'h0070, 16'h0071, 16'h0072, 16'h0073, 16'h0074, 16'h0075, 16'h0076};
	int          fails = 0, num_checks = 0, cyc = 0;
	wire  [3:0]  lvl;
	mfpc_board i_board (.i_drive(brd), .i_pin_val(op), .i_oe_n(oen), .o_wire(lvl));
	mfpc_pin_control i_dut (.i_clk(i_clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wd),
		.i_reg_rd(rd), .o_reg_rdata(rdat), .i_pin(lvl), .o_pin(op), .o_pin_oe_n(oen), .i_loss_of_lock(lol),
		.i_holdover(hold), .i_ref0_los(l0), .i_ref1_los(l1), .o_clkout_pin_enable(en), .o_clkout_pin_gated(gt),
		.o_manual_reference_select(rs), .o_manual_reference_select_valid(rsv));
	always #2 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			end_of_test();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	function automatic void predict();
		e_en = 8'hFF;
		{e_gt, e_op, e_iv, e_rs, e_rv} = '0;
		for (int n = 0; n < 4; n++) begin
			if (dir[n]) begin
				e_op[n] = ov[n];
				if (oc[n] == 3'h1 && n < 3) e_op[n] = n == 0 ? lol : n == 1 ? hold : l0;
				if (oc[n] == 3'h2 && n > 1) e_op[n] = l1;
			end else if (ic[n] == 3'h1 || ic[n] == 3'h2) begin
				e_gt[n + 4 * (ic[n] - 1)] = 1'b1;
				e_en[n + 4 * (ic[n] - 1)] = brd[n];
			end else if (ic[n] == 3'h5 && n == 2) begin
				e_rs = brd[2];
				e_rv = 1'b1;
			end else e_iv[n] = brd[n];
		end
	endfunction : predict
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(negedge i_clk);
		{addr, wd, wr} = {a, d, 1'b1};
		@(negedge i_clk);
		wr = 0;
	endtask : wr_reg
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input string n);
		@(negedge i_clk);
		{addr, rd} = {a, 1'b1};
		@(negedge i_clk);
		rd = 0;
		chk(n, rdat, e);
	endtask : rd_chk
	task automatic apply();
		logic [3:0] pi, po;
		wr_reg(MFPC_ADDR_DIR, {4'h0, dir});
		for (int b = 0; b < 3; b++) begin
			for (int n = 0; n < 4; n++) {pi[n], po[n]} = {ic[n][2-b], oc[n][2-b]};
			wr_reg(MFPC_ADDR_IFN2 + 16'(b), {4'h0, pi});
			wr_reg(MFPC_ADDR_OFN2 + 16'(b), {4'h0, po});
			rd_chk(MFPC_ADDR_OFN2 + 16'(b), {4'h0, po}, "ofn");
		end
		wr_reg(MFPC_ADDR_OVAL, {4'h0, ov});
	endtask : apply
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (16) @(negedge i_clk);
		rst = 0;
		foreach (regs[i]) rd_chk(regs[i], 8'h00, "reset value");
		for (int it = 0; it < 48; it++) begin
			seed = xs(seed);
			{dir, ov, lol, hold, l0, l1, brd} = seed[15:0];
			for (int n = 0; n < 4; n++) {ic[n], oc[n]} = it < 16 ? {2{3'(it)}} : 6'(seed >> (16 + 4 * n));
			if (it < 16) dir = it < 8 ? 4'h0 : 4'hF;
			{ic[3][2], oc[3][0]} = 2'b00;
			apply();
			repeat (4) @(negedge i_clk);
			predict();
			chk("clkout enable", en, e_en);
			chk("clkout gated", gt, e_gt);
			chk("pin drive", {4'h0, op}, {4'h0, e_op});
			chk("pin oe_n", {4'h0, oen}, {4'h0, ~dir});
			chk("refsel", {6'h0, rsv, rs}, {6'h0, e_rv, e_rs});
			rd_chk(MFPC_ADDR_IVAL, {4'h0, e_iv}, "input values");
		end
		rst = 1;
		@(negedge i_clk);
		rst = 0;
		chk("enable after reset", en, 8'hFF);
		chk("gated after reset", gt, 8'h00);
		chk("oe_n after reset", {4'h0, oen}, 8'h0F);
		chk("pin after reset", {4'h0, op}, 8'h00);
		chk("refsel after reset", {6'h0, rsv, rs}, 8'h00);
		rd_chk(MFPC_ADDR_DIR, 8'h00, "dir after reset");
		rd_chk(MFPC_ADDR_IFN1, 8'h00, "function after reset");
		rd_chk(MFPC_ADDR_OVAL, 8'h00, "values after reset");
		end_of_test();
	end
endmodule : multifunction_pin_control_test
